/* hw/exec_pkg.sv */
`default_nettype none
package exec_pkg;

	// ----------------------------------------------------------------
	// Widths
	// ----------------------------------------------------------------
	localparam int PC_W   = 21;
	localparam int ADDR_W = 12;

	// ----------------------------------------------------------------
	// Instruction word fields
	// ----------------------------------------------------------------
	localparam int DEST_BIT = 9;
	localparam int ACC_BIT  = 8;
	localparam logic [5:0] ADD_CARRY_PFX = 6'h08;
	localparam logic [5:0] AND_REG_PFX   = 6'h05;
	localparam logic [7:0] AND_LIT_HI    = 8'h0B;
	localparam logic [7:0] BR_CARRY_HI   = 8'hE2;

	// ----------------------------------------------------------------
	// Operand addressing
	// ----------------------------------------------------------------
	localparam logic [7:0] ACCESS_SPLIT = 8'h60;
	localparam logic [7:0] IDX_MAX      = 8'h5F;
	localparam logic [3:0] LOW_BANK     = 4'h0;
	localparam logic [3:0] HIGH_BANK    = 4'hF;

	// ----------------------------------------------------------------
	// Status flag positions
	// ----------------------------------------------------------------
	localparam int FLG_C  = 0;
	localparam int FLG_DC = 1;
	localparam int FLG_Z  = 2;
	localparam int FLG_OV = 3;
	localparam int FLG_N  = 4;

	// ----------------------------------------------------------------
	// Reset values and counts
	// ----------------------------------------------------------------
	localparam logic [7:0]      ACCUM_RST = 8'h00;
	localparam logic [4:0]      FLAGS_RST = 5'h00;
	localparam logic [PC_W-1:0] PC_RST    = 21'h00000;
	localparam logic [15:0]     IR_RST    = 16'h0000;
	localparam logic [PC_W-1:0] PC_STEP   = 21'h00002;
	localparam int              NOP_QUARTERS = 4;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		PH_Q1 = 4'h1,
		PH_Q2 = 4'h2,
		PH_Q3 = 4'h4,
		PH_Q4 = 4'h8
	} phase_t;

	typedef enum logic [2:0] {
		OP_NONE = 3'h0,
		OP_ADDC = 3'h1,
		OP_ANDL = 3'h2,
		OP_ANDR = 3'h3,
		OP_BRC  = 3'h4
	} op_t;

endpackage
`default_nettype wire

/* hw/operand_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface operand_if;
	logic        acc_bit;
	logic [7:0]  reg_f;
	logic [3:0]  bank;
	logic        ext_en;
	logic [11:0] base;
	logic [11:0] addr;

	modport req (output acc_bit, output reg_f, output bank, output ext_en,
		output base, input addr);
	modport res (input acc_bit, input reg_f, input bank, input ext_en,
		input base, output addr);
endinterface
`default_nettype wire

/* hw/operand_resolve.sv */
`timescale 1ns/1ps
`default_nettype none
module operand_resolve
	import exec_pkg::*;
(
	operand_if.res opd
);

	always_comb begin
		if (opd.ext_en && !opd.acc_bit && opd.reg_f <= IDX_MAX) begin
			opd.addr = opd.base + {4'h0, opd.reg_f};
		end else if (opd.acc_bit) begin
			opd.addr = {opd.bank, opd.reg_f};
		end else if (opd.reg_f < ACCESS_SPLIT) begin
			opd.addr = {LOW_BANK, opd.reg_f};
		end else begin
			opd.addr = {HIGH_BANK, opd.reg_f};
		end
	end

endmodule
`default_nettype wire

/* hw/exec_core.sv */
`timescale 1ns/1ps
`default_nettype none
module exec_core
	import exec_pkg::*;
(
	// Clock and reset
	input  wire logic                      SYS_CLK,
	input  wire logic                      RST_B,
	// Instruction stream
	input  wire logic [15:0]               INSTR_WORD,
	output logic                           PHASE_Q1,
	output logic [exec_pkg::PC_W-1:0]      PROG_CNT,
	// Addressing controls
	input  wire logic [3:0]                BANK_SELECT_REGISTER,
	input  wire logic                      EXT_SET_EN,
	input  wire logic [exec_pkg::ADDR_W-1:0] INDEX_BASE,
	// Data memory
	output logic [exec_pkg::ADDR_W-1:0]    MEM_ADDR,
	output logic                           MEM_RD_EN,
	input  wire logic [7:0]                MEM_RD_DATA,
	output logic                           MEM_WR_EN,
	output logic [7:0]                     MEM_WR_DATA,
	// Core state
	output logic [7:0]                     ACCUM,
	output logic                           NEGATIVE_FLAG,
	output logic                           SIGNED_RANGE_EXCEEDED_FLAG,
	output logic                           ZERO_FLAG,
	output logic                           HALF_CARRY_FLAG,
	output logic                           CARRY_FLAG,
	output logic                           BRANCH_NOP
);
	import exec_pkg::*;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	phase_t          phase_ff, nxt_phase;
	op_t             op_ff, nxt_op;
	logic [15:0]     ir_ff, nxt_ir;
	logic [ADDR_W-1:0] addr_ff, nxt_addr;
	logic [7:0]      opnd_ff, nxt_opnd;
	logic [7:0]      res_ff, nxt_res;
	logic [7:0]      accum_ff, nxt_accum;
	logic [4:0]      flags_ff, nxt_flags;
	logic [4:0]      pend_ff, nxt_pend;
	logic [PC_W-1:0] pc_ff, nxt_pc;
	logic            take_ff, nxt_take;
	logic            nop_ff, nxt_nop;

	logic            dest_mem;
	logic            reads_reg;
	logic [8:0]      sum9;
	logic [4:0]      low5;
	logic [PC_W-1:0] br_off;

	operand_if opd ();

	assign opd.acc_bit = INSTR_WORD[ACC_BIT];
	assign opd.reg_f   = INSTR_WORD[7:0];
	assign opd.bank    = BANK_SELECT_REGISTER;
	assign opd.ext_en  = EXT_SET_EN;
	assign opd.base    = INDEX_BASE;

	operand_resolve u_resolve (
		.opd (opd.res)
	);

	function automatic op_t decode(input logic [15:0] w);
		if (w[15:8] == BR_CARRY_HI)
			return OP_BRC;
		else if (w[15:8] == AND_LIT_HI)
			return OP_ANDL;
		else if (w[15:10] == ADD_CARRY_PFX)
			return OP_ADDC;
		else if (w[15:10] == AND_REG_PFX)
			return OP_ANDR;
		else
			return OP_NONE;
	endfunction

	assign reads_reg = (op_ff == OP_ADDC) || (op_ff == OP_ANDR);
	assign dest_mem  = reads_reg && ir_ff[DEST_BIT];
	assign sum9 = {1'b0, accum_ff} + {1'b0, opnd_ff}
		+ {8'h00, flags_ff[FLG_C]};
	assign low5 = {1'b0, accum_ff[3:0]} + {1'b0, opnd_ff[3:0]}
		+ {4'h0, flags_ff[FLG_C]};
	assign br_off = {{12{ir_ff[7]}}, ir_ff[7:0], 1'b0};

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		nxt_phase = phase_ff;
		nxt_op    = op_ff;
		nxt_ir    = ir_ff;
		nxt_addr  = addr_ff;
		nxt_opnd  = opnd_ff;
		nxt_res   = res_ff;
		nxt_accum = accum_ff;
		nxt_flags = flags_ff;
		nxt_pend  = pend_ff;
		nxt_pc    = pc_ff;
		nxt_take  = take_ff;
		nxt_nop   = nop_ff;
		unique case (phase_ff)
			PH_Q1: begin
				nxt_phase = PH_Q2;
				nxt_ir    = INSTR_WORD;
				nxt_op    = nop_ff ? OP_NONE : decode(INSTR_WORD);
				nxt_addr  = opd.addr;
				nxt_pc    = pc_ff + PC_STEP;
			end
			PH_Q2: begin
				nxt_phase = PH_Q3;
				nxt_opnd  = reads_reg ? MEM_RD_DATA : ir_ff[7:0];
			end
			PH_Q3: begin
				nxt_phase = PH_Q4;
				nxt_pend  = flags_ff;
				nxt_take  = (op_ff == OP_BRC) && flags_ff[FLG_C];
				unique case (op_ff)
					OP_ADDC: begin
						nxt_res = sum9[7:0];
						nxt_pend[FLG_C]  = sum9[8];
						nxt_pend[FLG_DC] = low5[4];
						nxt_pend[FLG_OV] = (accum_ff[7] == opnd_ff[7])
							&& (sum9[7] != accum_ff[7]);
						nxt_pend[FLG_N]  = sum9[7];
						nxt_pend[FLG_Z]  = (sum9[7:0] == 8'h00);
					end
					OP_ANDL, OP_ANDR: begin
						nxt_res = accum_ff & opnd_ff;
						nxt_pend[FLG_N] = accum_ff[7] & opnd_ff[7];
						nxt_pend[FLG_Z] = ((accum_ff & opnd_ff) == 8'h00);
					end
					OP_BRC, OP_NONE: begin
						nxt_res = res_ff;
					end
				endcase
			end
			PH_Q4: begin
				nxt_phase = PH_Q1;
				nxt_nop   = take_ff;
				if (op_ff != OP_BRC && op_ff != OP_NONE)
					nxt_flags = pend_ff;
				if (op_ff != OP_BRC && op_ff != OP_NONE && !dest_mem)
					nxt_accum = res_ff;
				if (take_ff)
					nxt_pc = pc_ff + br_off;
			end
			default: begin
				nxt_phase = PH_Q1;
			end
		endcase
	end

	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			phase_ff <= PH_Q1;
			op_ff    <= OP_NONE;
			ir_ff    <= IR_RST;
			addr_ff  <= '0;
			opnd_ff  <= ACCUM_RST;
			res_ff   <= ACCUM_RST;
			accum_ff <= ACCUM_RST;
			flags_ff <= FLAGS_RST;
			pend_ff  <= FLAGS_RST;
			pc_ff    <= PC_RST;
			take_ff  <= 1'b0;
			nop_ff   <= 1'b0;
		end else begin
			phase_ff <= nxt_phase;
			op_ff    <= nxt_op;
			ir_ff    <= nxt_ir;
			addr_ff  <= nxt_addr;
			opnd_ff  <= nxt_opnd;
			res_ff   <= nxt_res;
			accum_ff <= nxt_accum;
			flags_ff <= nxt_flags;
			pend_ff  <= nxt_pend;
			pc_ff    <= nxt_pc;
			take_ff  <= nxt_take;
			nop_ff   <= nxt_nop;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign PHASE_Q1    = (phase_ff == PH_Q1);
	assign PROG_CNT    = pc_ff;
	assign MEM_ADDR    = addr_ff;
	assign MEM_RD_EN   = (phase_ff == PH_Q2) && reads_reg;
	assign MEM_WR_EN   = (phase_ff == PH_Q4) && dest_mem;
	assign MEM_WR_DATA = res_ff;
	assign ACCUM       = accum_ff;
	assign NEGATIVE_FLAG              = flags_ff[FLG_N];
	assign SIGNED_RANGE_EXCEEDED_FLAG = flags_ff[FLG_OV];
	assign ZERO_FLAG                  = flags_ff[FLG_Z];
	assign HALF_CARRY_FLAG            = flags_ff[FLG_DC];
	assign CARRY_FLAG                 = flags_ff[FLG_C];
	assign BRANCH_NOP                 = nop_ff;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!RST_B);

	sequence s_quarters;
		phase_ff == PH_Q2 ##1 phase_ff == PH_Q3 ##1 phase_ff == PH_Q4;
	endsequence
	property p_quarters;
		phase_ff == PH_Q1 |=> s_quarters ##1 phase_ff == PH_Q1;
	endproperty
	a_quarters: assert property (p_quarters)
		else $error("Quarter phases out of order.");
	// The carry is checked against the operands, not the pending copy.
	property p_add_sum;
		phase_ff == PH_Q3 && op_ff == OP_ADDC |=> res_ff == 8'($past(
			accum_ff) + $past(opnd_ff) + {7'h00, $past(flags_ff[FLG_C])})
			##1 {flags_ff[FLG_C], res_ff} == 9'($past(accum_ff, 2))
			+ 9'($past(opnd_ff, 2)) + 9'($past(flags_ff[FLG_C], 2));
	endproperty
	a_add_sum: assert property (p_add_sum)
		else $error("Add with carry gave a wrong sum.");
	property p_dest;
		phase_ff == PH_Q4 && reads_reg |-> (MEM_WR_EN == ir_ff[DEST_BIT])
			##1 (accum_ff == ($past(ir_ff[DEST_BIT]) ? $past(accum_ff)
			: $past(res_ff)));
	endproperty
	a_dest: assert property (p_dest)
		else $error("Result went to the wrong destination.");
	property p_bank;
		phase_ff == PH_Q1 && INSTR_WORD[ACC_BIT] |=>
			addr_ff == {$past(BANK_SELECT_REGISTER), $past(INSTR_WORD[7:0])};
	endproperty
	a_bank: assert property (p_bank)
		else $error("Banked operand address is wrong.");
	property p_indexed;
		phase_ff == PH_Q1 && EXT_SET_EN && !INSTR_WORD[ACC_BIT]
			&& INSTR_WORD[7:0] <= IDX_MAX |=>
			addr_ff == $past(INDEX_BASE) + {4'h0, $past(INSTR_WORD[7:0])};
	endproperty
	a_indexed: assert property (p_indexed)
		else $error("Indexed operand address is wrong.");
	property p_and_flags;
		phase_ff == PH_Q4 && (op_ff == OP_ANDL || op_ff == OP_ANDR) |=>
			flags_ff[FLG_N] == $past(res_ff[7])
			&& flags_ff[FLG_Z] == ($past(res_ff) == 8'h00)
			&& $stable(flags_ff[FLG_C]) && $stable(flags_ff[FLG_OV])
			&& $stable(flags_ff[FLG_DC]);
	endproperty
	a_and_flags: assert property (p_and_flags)
		else $error("AND changed the wrong flags.");
	property p_branch_pc;
		phase_ff == PH_Q4 && take_ff |=>
			pc_ff == $past(pc_ff) + $past(br_off) && $stable(flags_ff);
	endproperty
	a_branch_pc: assert property (p_branch_pc)
		else $error("Branch target or flags wrong.");
	property p_branch_nop;
		phase_ff == PH_Q4 && take_ff |=> nop_ff [*4] ##1 !nop_ff
			&& op_ff == OP_NONE;
	endproperty
	a_branch_nop: assert property (p_branch_nop)
		else $error("Taken branch missed its no-op cycle.");
	property p_no_take;
		phase_ff == PH_Q4 && op_ff == OP_BRC && !take_ff |=>
			!nop_ff && pc_ff == $past(pc_ff);
	endproperty
	a_no_take: assert property (p_no_take)
		else $error("Untaken branch disturbed the sequence.");
	property p_read_q2;
		MEM_RD_EN |-> phase_ff == PH_Q2 ##2 !MEM_RD_EN;
	endproperty
	a_read_q2: assert property (p_read_q2)
		else $error("Operand read outside the second quarter.");
endmodule
`default_nettype wire

/* tb/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
	import exec_pkg::*;

	// ------------------------------------------------------------
	// Signals and bench state
	// ------------------------------------------------------------
	logic			sys_clk, rst_b, ext_en, phase_q1;
	logic			rd_en, wr_en, br_nop, rd_q2, wr_q4;
	logic			n_f, ov_f, z_f, dc_f, c_f;
	logic [15:0]		instr;
	logic [3:0]		bank;
	logic [ADDR_W-1:0]	ibase, maddr;
	logic [7:0]		rd_data, wr_data, accum, e_acc;
	logic [PC_W-1:0]	pc;
	logic [4:0]		e_flg;
	logic [7:0]		mem [0:4095];
	int			n_fail, checked, cyc;

	exec_core i_dut (
		.SYS_CLK(sys_clk), .RST_B(rst_b), .INSTR_WORD(instr),
		.PHASE_Q1(phase_q1), .PROG_CNT(pc),
		.BANK_SELECT_REGISTER(bank), .EXT_SET_EN(ext_en),
		.INDEX_BASE(ibase), .MEM_ADDR(maddr), .MEM_RD_EN(rd_en),
		.MEM_RD_DATA(rd_data), .MEM_WR_EN(wr_en),
		.MEM_WR_DATA(wr_data), .ACCUM(accum), .NEGATIVE_FLAG(n_f),
		.SIGNED_RANGE_EXCEEDED_FLAG(ov_f), .ZERO_FLAG(z_f),
		.HALF_CARRY_FLAG(dc_f), .CARRY_FLAG(c_f), .BRANCH_NOP(br_nop)
	);

	// ------------------------------------------------------------
	// Clock, data memory and hang guard
	// ------------------------------------------------------------
	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end

	// Every byte differs from its bank neighbours, so a wrong bank shows.
	assign rd_data = mem[maddr];
	always @(posedge sys_clk) begin
		if (wr_en === 1'b1)
			mem[maddr] <= wr_data;
	end

	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 3000) begin
			n_fail++;
			$display("mismatch at %0t: timeout", $time);
			wrap_up;
		end
	end

	// ------------------------------------------------------------
	// Compare tasks and verdict
	// ------------------------------------------------------------
	task automatic chk_val(input logic [20:0] got, exp, input string s);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch at %0t: %s got %h exp %h", $time, s, got, exp);
		end
	endtask

	task automatic chk_flg(input string s);
		checked++;
		if ({n_f, ov_f, z_f, dc_f, c_f} !== e_flg) begin
			n_fail++;
			$display("mismatch at %0t: %s flags exp %b", $time, s, e_flg);
		end
	endtask

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// ------------------------------------------------------------
	// Access protocol: one word per four-quarter cycle
	// ------------------------------------------------------------
	task automatic exec(input logic [15:0] w);
		int k;
		k = 0;
		while (phase_q1 !== 1'b1 && k < 8) begin
			@(negedge sys_clk);
			k++;
		end
		instr = w;
		for (k = 0; k < 4; k++) begin
			@(negedge sys_clk);
			if (k == 0)
				rd_q2 = rd_en;
			if (k == 2)
				wr_q4 = wr_en;
		end
	endtask

	function automatic logic [11:0] ea(input logic a, input logic [7:0] f);
		if (a)
			return {bank, f};
		if (ext_en && f <= IDX_MAX)
			return ibase + {4'h0, f};
		return (f < ACCESS_SPLIT) ? {LOW_BANK, f} : {HIGH_BANK, f};
	endfunction

	task automatic reg_op(input logic add, d, a, input logic [7:0] f, v);
		logic [11:0]	ad;
		logic [8:0]	s;
		logic [4:0]	lo;
		logic [7:0]	r;
		ad = ea(a, f);
		mem[ad] = v;
		s = {1'b0, e_acc} + {1'b0, v} + {8'h00, e_flg[FLG_C]};
		lo = {1'b0, e_acc[3:0]} + {1'b0, v[3:0]} + {4'h0, e_flg[FLG_C]};
		r = add ? s[7:0] : (e_acc & v);
		if (add)
			e_flg = {r[7], e_acc[7] == v[7] && r[7] != e_acc[7],
				r == 8'h00, lo[4], s[8]};
		else
			e_flg = {r[7], e_flg[FLG_OV], r == 8'h00, e_flg[1:0]};
		exec({add ? ADD_CARRY_PFX : AND_REG_PFX, d, a, f});
		chk_val({rd_q2, wr_q4}, {1'b1, d}, "strobes");
		if (d)
			chk_val(mem[ad], r, "memory");
		else
			e_acc = r;
		chk_val(accum, e_acc, "accum");
		chk_flg("reg op");
	endtask

	task automatic andl(input logic [7:0] k);
		e_acc = e_acc & k;
		e_flg[FLG_N] = e_acc[7];
		e_flg[FLG_Z] = (e_acc == 8'h00);
		exec({AND_LIT_HI, k});
		chk_val({rd_q2, wr_q4}, 2'b00, "no memory");
		chk_val(accum, e_acc, "accum");
		chk_flg("literal");
	endtask

	task automatic branch(input logic [7:0] n);
		logic [20:0] p;
		p = pc;
		exec({BR_CARRY_HI, n});
		if (e_flg[FLG_C]) begin
			chk_val(pc, p + 21'd2 + {{12{n[7]}}, n, 1'b0}, "jump");
			chk_val(br_nop, 1'b1, "idle cycle");
			p = pc;
			// A register add with write-back would strobe the memory if run.
			exec({ADD_CARRY_PFX, 2'b10, 8'h12});
			chk_val({rd_q2, wr_q4}, 2'b00, "dropped strobes");
			chk_val(accum, e_acc, "dropped word");
			chk_val(pc, p + 21'd2, "after idle");
		end else begin
			chk_val(pc, p + 21'd2, "sequential");
			chk_val(br_nop, 1'b0, "no idle");
		end
		chk_flg("branch");
	endtask

	// ------------------------------------------------------------
	// Test sequence
	// ------------------------------------------------------------
	initial begin
		rst_b = 1'b0;
		instr = IR_RST;
		bank = 4'h0;
		ext_en = 1'b0;
		ibase = 12'h000;
		e_acc = ACCUM_RST;
		e_flg = FLAGS_RST;
		n_fail = 0;
		checked = 0;
		cyc = 0;
		for (int i = 0; i < 4096; i++)
			mem[i] = i[7:0] ^ i[11:4];
		repeat (12) @(negedge sys_clk);
		chk_val(pc, PC_RST, "reset pc");
		chk_flg("reset");
		rst_b = 1'b1;
		reg_op(1'b1, 1'b0, 1'b0, 8'h12, 8'hFF);
		bank = 4'h3;
		reg_op(1'b1, 1'b0, 1'b1, 8'h80, 8'h01);
		branch(8'hFE);
		reg_op(1'b1, 1'b0, 1'b0, 8'hA0, 8'h4C);
		reg_op(1'b1, 1'b0, 1'b0, 8'h33, 8'h40);
		branch(8'h7F);
		reg_op(1'b1, 1'b0, 1'b1, 8'h07, 8'h80);
		branch(8'h80);
		$display("test add and branch done");
		andl(8'h5F);
		andl(8'h80);
		reg_op(1'b1, 1'b0, 1'b0, 8'h30, 8'hA3);
		reg_op(1'b0, 1'b1, 1'b0, 8'hF0, 8'h5F);
		reg_op(1'b0, 1'b0, 1'b1, 8'h44, 8'hC6);
		$display("test logic ops done");
		ext_en = 1'b1;
		ibase = 12'hFC0;
		reg_op(1'b1, 1'b1, 1'b0, 8'h5F, 8'h11);
		reg_op(1'b1, 1'b0, 1'b0, 8'h60, 8'h22);
		reg_op(1'b0, 1'b0, 1'b1, 8'h05, 8'hF0);
		$display("test indexed mode done");
		wrap_up;
	end
endmodule
`default_nettype wire
